/* File: pkg/mdc_defs.svh */
// Offsets, field positions and reset values of the datapath configuration register
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH
`define MDC_ADDR_W 12
`define MDC_CONFIG_OFFSET 12'h060
`define MDC_CONFIG_RESET 32'h0000_0000
`define MDC_CONFIG_WMASK 32'h0000_3F7B
`define MDC_BIT_REACT_LPF_BYP 13
`define MDC_BIT_ACT_LPF_BYP 12
`define MDC_BIT_NEUT_INT_EN 11
`define MDC_BIT_NOMINAL_VOLTAGE_RMS_C 10
`define MDC_BIT_NOMINAL_VOLTAGE_RMS_B 9
`define MDC_BIT_NOMINAL_VOLTAGE_RMS_A 8
`define MDC_BIT_ZX_SRC 6
`define MDC_BIT_PHASE_INT_EN 5
`define MDC_BIT_MULTI_EN 4
`define MDC_BIT_HPF_BYP 3
`define MDC_REGION_OFF 4'hF
`define MDC_NUM_REGIONS 5
`endif

/* File: pkg/mdc_pkg.sv */
// Types shared by the datapath configuration block
`default_nettype none
package mdc_pkg;
    typedef enum logic [1:0] {
        MDC_SUM_PHASES_A,
        MDC_SUM_PLUS_NEUTRAL,
        MDC_SUM_MINUS_NEUTRAL,
        MDC_SUM_PHASES_B
    } mdc_sum_cfg_t;
endpackage
`default_nettype wire

/* File: rtl/mdc_datapath_config.sv */
// Metering datapath configuration register and its steering outputs
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defs.svh"
module mdc_datapath_config #(
    parameter int SAMPLE_W = 24,
    parameter int RMS_W = 24
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    // Register port
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [`MDC_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_hit_o,
    // Datapath timing
    input wire logic sample_strobe_i,
    // Current samples
    input wire logic [SAMPLE_W-1:0] phase_a_current_sample_i,
    input wire logic [SAMPLE_W-1:0] phase_b_current_sample_i,
    input wire logic [SAMPLE_W-1:0] phase_c_current_sample_i,
    input wire logic [SAMPLE_W-1:0] neutral_current_sample_i,
    output logic [SAMPLE_W+1:0] current_sum_o,
    // Multipoint inputs per phase, A in the low slice
    input wire logic [3*RMS_W-1:0] current_rms_i,
    input wire logic [12*RMS_W-1:0] multipoint_low_threshold_i,
    input wire logic [12*RMS_W-1:0] multipoint_high_threshold_i,
    output logic [11:0] gain_region_o,
    // Steering outputs
    output logic reactive_lpf_bypass_o,
    output logic active_lpf_bypass_o,
    output logic neutral_integrator_enable_o,
    output logic phase_integrator_enable_o,
    output logic [2:0] nominal_voltage_select_o,
    output logic zero_cross_source_select_o,
    output logic multipoint_comp_enable_o,
    output logic highpass_bypass_o
);
    import mdc_pkg::*;

    initial begin
        if (SAMPLE_W < 2 || RMS_W < 2) $error("widths too small");
    end

    typedef struct packed {
        logic [31:0] cfg;      // Software copy
        logic [31:0] active;   // Copy the datapath sees
        logic [SAMPLE_W+1:0] sum;
    } mdc_state_t;

    mdc_state_t state_q;
    mdc_state_t state_d;
    logic cfg_hit;
    logic [SAMPLE_W+1:0] phase_sum;
    logic [SAMPLE_W+1:0] neutral_ext;
    mdc_sum_cfg_t sum_cfg;

    assign cfg_hit = (reg_addr_i == `MDC_CONFIG_OFFSET);

    // ---------------------------------------------
    // Current sum
    // ---------------------------------------------
    // Sign-extend by two bits so three or four terms never overflow.
    assign phase_sum = {{2{phase_a_current_sample_i[SAMPLE_W-1]}}, phase_a_current_sample_i}
        + {{2{phase_b_current_sample_i[SAMPLE_W-1]}}, phase_b_current_sample_i}
        + {{2{phase_c_current_sample_i[SAMPLE_W-1]}}, phase_c_current_sample_i};
    assign neutral_ext = {{2{neutral_current_sample_i[SAMPLE_W-1]}}, neutral_current_sample_i};
    assign sum_cfg = mdc_sum_cfg_t'(state_q.active[1:0]);

    // ---------------------------------------------
    // Next state
    // ---------------------------------------------
    always_comb begin
        state_d = state_q;
        if (reg_write_i && cfg_hit) begin
            state_d.cfg = reg_wdata_i & `MDC_CONFIG_WMASK;
        end
        // Only load on a sample boundary so a sample in flight keeps its setting
        if (sample_strobe_i) begin
            state_d.active = state_q.cfg;
            case (sum_cfg)
                MDC_SUM_PLUS_NEUTRAL: state_d.sum = phase_sum + neutral_ext;
                MDC_SUM_MINUS_NEUTRAL: state_d.sum = phase_sum - neutral_ext;
                MDC_SUM_PHASES_A: state_d.sum = phase_sum;
                MDC_SUM_PHASES_B: state_d.sum = phase_sum;
                default: state_d.sum = phase_sum;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ---------------------------------------------
    // Region choosers, one per phase
    // ---------------------------------------------
    for (genvar p = 0; p < 3; p++) begin : g_phase
        mdc_region_select #(
            .RMS_W(RMS_W)
        ) u_region (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .enable_i(state_q.active[`MDC_BIT_MULTI_EN]),
            .sample_strobe_i(sample_strobe_i),
            .current_rms_i(current_rms_i[p*RMS_W +: RMS_W]),
            .multipoint_low_threshold_i(multipoint_low_threshold_i[p*4*RMS_W +: 4*RMS_W]),
            .multipoint_high_threshold_i(multipoint_high_threshold_i[p*4*RMS_W +: 4*RMS_W]),
            .region_o(gain_region_o[p*4 +: 4])
        );
    end

    // ---------------------------------------------
    // Read port and steering
    // ---------------------------------------------
    assign reg_hit_o = cfg_hit;
    assign reg_rdata_o = (reg_read_i && cfg_hit) ? state_q.cfg : 32'h0000_0000;
    assign current_sum_o = state_q.sum;
    assign reactive_lpf_bypass_o = state_q.active[`MDC_BIT_REACT_LPF_BYP];
    assign active_lpf_bypass_o = state_q.active[`MDC_BIT_ACT_LPF_BYP];
    assign neutral_integrator_enable_o = state_q.active[`MDC_BIT_NEUT_INT_EN];
    assign nominal_voltage_select_o = state_q.active[`MDC_BIT_NOMINAL_VOLTAGE_RMS_C:`MDC_BIT_NOMINAL_VOLTAGE_RMS_A];
    assign zero_cross_source_select_o = state_q.active[`MDC_BIT_ZX_SRC];
    assign phase_integrator_enable_o = state_q.active[`MDC_BIT_PHASE_INT_EN];
    assign multipoint_comp_enable_o = state_q.active[`MDC_BIT_MULTI_EN];
    assign highpass_bypass_o = state_q.active[`MDC_BIT_HPF_BYP];
endmodule // mdc_datapath_config
`default_nettype wire

/* File: rtl/mdc_region_select.sv */
// Multipoint gain region chooser for one phase
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defs.svh"
module mdc_region_select #(
    parameter int RMS_W = 24
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic enable_i,
    input wire logic sample_strobe_i,
    input wire logic [RMS_W-1:0] current_rms_i,
    input wire logic [4*RMS_W-1:0] multipoint_low_threshold_i,
    input wire logic [4*RMS_W-1:0] multipoint_high_threshold_i,
    output logic [3:0] region_o
);
    import mdc_pkg::*;

    initial begin
        if (RMS_W < 2) $error("RMS_W too small");
    end

    typedef struct packed {
        logic [3:0] region;
    } mdc_rs_state_t;

    mdc_rs_state_t state_q;
    mdc_rs_state_t state_d;

    // ---------------------------------------------
    // Region walk with hysteresis
    // ---------------------------------------------
    // Step up past a high threshold, down below a low one; the gap between the two
    // keeps the gain from chattering at a boundary.
    always_comb begin
        state_d = state_q;
        if (!enable_i) begin
            state_d.region = `MDC_REGION_OFF;
        end else if (sample_strobe_i) begin
            if (state_q.region > 4'h4) begin
                state_d.region = 4'h0;
            end else if (state_q.region < 4'h4 &&
                    current_rms_i > multipoint_high_threshold_i[state_q.region*RMS_W +: RMS_W]) begin
                state_d.region = state_q.region + 4'h1;
            end else if (state_q.region > 4'h0 &&
                    current_rms_i < multipoint_low_threshold_i[(state_q.region-4'h1)*RMS_W +: RMS_W]) begin
                state_d.region = state_q.region - 4'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= '{region: 4'hF};
        end else begin
            state_q <= state_d;
        end
    end

    assign region_o = state_q.region;
endmodule // mdc_region_select
`default_nettype wire

/* File: verification/mdc_datapath_config_sva.sv */
// Assertion checker for the datapath configuration block
`timescale 1ns/1ps
`default_nettype none
module mdc_datapath_config_sva #(
    parameter int SAMPLE_W = 24,
    parameter int RMS_W = 24
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic reg_hit_o,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic sample_strobe_i,
    input wire logic [SAMPLE_W+1:0] current_sum_o,
    input wire logic [11:0] gain_region_o,
    input wire logic reactive_lpf_bypass_o,
    input wire logic active_lpf_bypass_o,
    input wire logic neutral_integrator_enable_o,
    input wire logic phase_integrator_enable_o,
    input wire logic [2:0] nominal_voltage_select_o,
    input wire logic zero_cross_source_select_o,
    input wire logic multipoint_comp_enable_o,
    input wire logic highpass_bypass_o
);
    // ------
    // Steering outputs laid out as the register bits
    // ------
    logic [13:0] steer;
    assign steer = {reactive_lpf_bypass_o, active_lpf_bypass_o, neutral_integrator_enable_o,
        nominal_voltage_select_o, 1'b0, zero_cross_source_select_o, phase_integrator_enable_o,
        multipoint_comp_enable_o, highpass_bypass_o, 3'h0};
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // A strobe in the write cycle would load the old value, so the two are kept apart
    sequence s_cfg_write;
        reg_write_i && reg_hit_o && !sample_strobe_i;
    endsequence
    sequence s_lone_strobe;
        sample_strobe_i && !reg_write_i;
    endsequence
    a_write_apply: assert property (s_cfg_write ##1 s_lone_strobe
        |=> steer == ($past(reg_wdata_i[13:0], 2) & 14'h3F78)) else $error("steering mismatch");
    a_steer_hold: assert property (!$past(sample_strobe_i) |-> $stable(steer))
        else $error("steering moved without a strobe");
    a_sum_hold: assert property (!$past(sample_strobe_i) |-> $stable(current_sum_o))
        else $error("current sum moved without a strobe");
    a_region_off: assert property (!multipoint_comp_enable_o [*2] |-> gain_region_o == 12'hFFF)
        else $error("region not parked while compensation is off");
    a_region_step: assert property ($past(multipoint_comp_enable_o) && multipoint_comp_enable_o
        && !$past(sample_strobe_i) |-> $stable(gain_region_o)) else $error("region moved early");
    a_read_gate: assert property (!(reg_read_i && reg_hit_o) |-> reg_rdata_o == 32'h0)
        else $error("read data without a selected read");
    a_reserved_zero: assert property (reg_read_i |-> (reg_rdata_o & 32'hFFFF_C084) == 32'h0)
        else $error("reserved bit reads nonzero");
    a_read_back: assert property (s_cfg_write ##1 (reg_read_i && reg_hit_o)
        |-> reg_rdata_o == ($past(reg_wdata_i) & 32'h0000_3F7B)) else $error("readback mismatch");
endmodule // mdc_datapath_config_sva
bind mdc_datapath_config mdc_datapath_config_sva #(.SAMPLE_W(SAMPLE_W), .RMS_W(RMS_W)) u_sva (
    .clock_i, .rstn_i, .reg_write_i, .reg_read_i, .reg_hit_o, .reg_wdata_i, .reg_rdata_o,
    .sample_strobe_i, .current_sum_o, .gain_region_o, .reactive_lpf_bypass_o,
    .active_lpf_bypass_o, .neutral_integrator_enable_o, .phase_integrator_enable_o,
    .nominal_voltage_select_o, .zero_cross_source_select_o, .multipoint_comp_enable_o,
    .highpass_bypass_o);
`default_nettype wire

/* File: verification/mdc_datapath_config_tb.sv */
// Self-checking testbench for the datapath configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end
module mdc_datapath_config_tb;
    logic clock_i = 1'b0, rstn_i = 1'b0, write_s = 1'b0, read_s = 1'b0, strobe_s = 1'b0;
    logic [11:0] addr_s = 12'h000, region_s;
    logic [31:0] wdata_s = 32'h0, rdata_s;
    logic [13:0] steer_s;
    logic [9:0] sum_s;
    logic [23:0] rms_s = 24'hC8C8C8;
    logic [7:0] neutral_s = 8'h07;
    logic hit_s;
    int err_total = 0, n_tests = 0;
    // Columns: write data, expected readback, expected current sum
    logic [31:0] rows [5][3] = '{'{32'hFFFF_FFFF, 32'h0000_3F7B, 32'h0000_007B},
        '{32'h0000_0001, 32'h0000_0001, 32'h0000_0082}, '{32'h0000_8002, 32'h0000_0002, 32'h0000_0074},
        '{32'h0000_2A28, 32'h0000_2A28, 32'h0000_007B}, '{32'h0000_D550, 32'h0000_1550, 32'h0000_007B}};
    mdc_datapath_config #(.SAMPLE_W(8), .RMS_W(8)) dut_u (.clock_i(clock_i), .rstn_i(rstn_i),
        .reg_write_i(write_s), .reg_read_i(read_s), .reg_addr_i(addr_s), .reg_wdata_i(wdata_s),
        .reg_rdata_o(rdata_s), .reg_hit_o(hit_s), .sample_strobe_i(strobe_s),
        .phase_a_current_sample_i(8'h64), .phase_b_current_sample_i(8'h14),
        .phase_c_current_sample_i(8'h03), .neutral_current_sample_i(neutral_s), .current_sum_o(sum_s),
        .current_rms_i(rms_s), .multipoint_low_threshold_i({12{8'h0A}}),
        .multipoint_high_threshold_i({3{32'h281E140A}}), .gain_region_o(region_s),
        .reactive_lpf_bypass_o(steer_s[13]), .active_lpf_bypass_o(steer_s[12]),
        .neutral_integrator_enable_o(steer_s[11]), .nominal_voltage_select_o(steer_s[10:8]),
        .zero_cross_source_select_o(steer_s[6]), .phase_integrator_enable_o(steer_s[5]),
        .multipoint_comp_enable_o(steer_s[4]), .highpass_bypass_o(steer_s[3]));
    // Reserved positions and the sum_cfg bits of the steering word have no output behind them
    assign {steer_s[7], steer_s[2:0]} = 4'h0;
    always #50 clock_i = ~clock_i;
    // ------
    // Bus cycles, all launched from the falling edge
    // ------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clock_i);
        {write_s, addr_s, wdata_s} = {1'b1, a, d};
        @(negedge clock_i);
        write_s = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        {read_s, addr_s} = {1'b1, a};
        @(negedge clock_i);
        `CHK(rdata_s, e)
        `CHK(hit_s, a == 12'h060)
        read_s = 1'b0;
        @(negedge clock_i);
    endtask
    // Strobes always leave a gap cycle so steering and sum settle between them
    task automatic pulse();
        strobe_s = 1'b1;
        @(negedge clock_i);
        strobe_s = 1'b0;
        @(negedge clock_i);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200_000 err_total++;
        close_out();
    end
    initial begin
        repeat (8) @(negedge clock_i);
        rstn_i = 1'b1;
        `CHK(region_s, 12'hFFF)
        rd(12'h060, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(12'h060, rows[i][0]);
            pulse();
            pulse();
            `CHK(steer_s & 14'h3F78, rows[i][1][13:0] & 14'h3F78)
            `CHK(sum_s, rows[i][2][9:0])
            rd(12'h060, rows[i][1]);
        end
        $display("row table done");
        `CHK(region_s, 12'h000)
        pulse();
        `CHK(region_s, 12'h111)
        repeat (4) pulse();
        `CHK(region_s, 12'h444)
        rms_s = 24'h0;
        pulse();
        `CHK(region_s, 12'h333)
        $display("region stepping done");
        {write_s, wdata_s, strobe_s} = {1'b1, 32'h0, 1'b1};
        @(negedge clock_i);
        {write_s, strobe_s} = 2'b00;
        `CHK(steer_s & 14'h3F78, 14'h1550)
        // Let an edge pass so the strobe is not driven twice in one step
        @(negedge clock_i);
        pulse();
        @(negedge clock_i);
        `CHK(steer_s & 14'h3F78, 14'h0000)
        `CHK(region_s, 12'hFFF)
        wr(12'h064, 32'hFFFF_FFFF);
        rd(12'h064, 32'h0);
        rd(12'h060, 32'h0);
        wr(12'h060, 32'hFFFF_FFFF);
        rd(12'h060, 32'h0000_3F7B);
        // A negative neutral sample checks the sign extension of the sum
        neutral_s = 8'hF9;
        wr(12'h060, 32'h0000_0001);
        pulse();
        pulse();
        `CHK(sum_s, 10'h074)
        rstn_i = 1'b0;
        @(negedge clock_i);
        rstn_i = 1'b1;
        rd(12'h060, 32'h0);
        `CHK({region_s, sum_s}, 22'h3F_FC00)
        $display("awkward cases done");
        close_out();
    end
endmodule // mdc_datapath_config_tb
`default_nettype wire
